// ---- bench/chan_access_timing_tb_top.sv ----
// Purpose: Self-checking bench for the channel-access timing block
// Assumes: Inputs change at the falling edge; grants logged after rise
// Notes:   Timing windows use bounds where slot phase is not visible
module chan_access_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = chan_timing_pkg::TICK_CYC;
  logic clk = 1'b0, rst = 1'b1, busy, stick, dv = 0, tl = 0, ta = 0;
  logic bl = 0, sr = 0;
  logic [3:0]  bo_ld = '0, gnt;
  logic [1:0]  pol = 2'h0, tr_ld = '0, otr;
  logic [9:0]  bo_v = '0;
  logic [15:0] dur = '0;
  logic [63:0] stamp = '0, tbv = '0, trv = '0, tsf;
  logic [31:0] scnt = 32'h0000_0005;
  logic        st, rt, nav, tbtt, clk_en, susp;
  logic [3:0]  glog[$];
  int          n_errors = 0, check_count = 0;

  always #10 clk = ~clk;
  always @(posedge clk) #2 if (gnt !== 4'h0) glog.push_back(gnt);

  medium_model i_phy (.clk_i(clk), .phy_busy_o(busy), .slow_tick_o(stick));
  chan_access_timing i_dut (
    .clk_i(clk), .rst_i(rst), .phy_busy_i(busy),
    .sifs_cyc_i(12'h005), .rifs_cyc_i(12'h003), .slot_cyc_i(12'h004),
    .bo_load_i(bo_ld), .bo_value_i(bo_v), .arb_policy_i(pol),
    .dur_valid_i(dv), .dur_value_i(dur), .tsf_load_i(tl),
    .tsf_stamp_i(stamp), .tsf_adv_i(ta), .tbtt_load_i(bl),
    .tbtt_value_i(tbv), .trig_load_i(tr_ld), .trig_value_i(trv),
    .sleep_req_i(sr), .sleep_count_i(scnt), .slow_tick_i(stick),
    .sifs_trig_o(st), .rifs_trig_o(rt), .ac_grant_o(gnt),
    .nav_busy_o(nav), .tbtt_o(tbtt), .offset_trig_o(otr), .tsf_o(tsf),
    .mac_clk_en_o(clk_en), .suspended_o(susp));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic t_reset;
    check({st, rt, gnt, nav, tbtt, otr, susp}, '0);
    check({tsf, clk_en}, {64'h0, 1'b1});
    $display("test reset done");
  endtask : t_reset

  task automatic t_spacing;
    int ts = 0, tr = 0, cs = 0, cr = 0;
    i_phy.occupy(4);
    for (int n = 1; n <= 20; n++) begin
      @(negedge clk);
      if (st === 1'b1) begin cs++; ts = n; end
      if (rt === 1'b1) begin cr++; tr = n; end
    end
    check(64'(ts), 64'd5);
    check(64'(tr), 64'd3);
    check(64'({cs, cr}), {32'd1, 32'd1});
    $display("test spacing done");
  endtask : t_spacing

  task automatic t_nav;
    int n;
    glog.delete();
    dv = 1'b1; dur = 16'h0003; bo_ld = 4'h1; bo_v = 10'h001;
    @(negedge clk); dv = 1'b0; bo_ld = 4'h0;
    @(negedge clk); check(nav, 1'b1);
    dv = 1'b1; dur = 16'h0001;
    @(negedge clk); dv = 1'b0;
    repeat (2 * TK - 8) @(negedge clk);
    check(nav, 1'b1);
    check(64'(glog.size()), 64'd0);
    for (n = 0; n < 4 * TK && nav !== 1'b0; n++) @(negedge clk);
    check(nav, 1'b0);
    repeat (24) @(negedge clk);
    check(64'(glog.size()), 64'd1);
    if (glog.size() > 0) check(glog[0], 4'h1);
    $display("test nav done");
  endtask : t_nav

  task automatic t_hold;
    glog.delete();
    bo_ld = 4'h4; bo_v = 10'h002;
    @(negedge clk); bo_ld = 4'h0;
    i_phy.occupy(30);
    check(64'(glog.size()), 64'd0);
    repeat (24) @(negedge clk);
    check(64'(glog.size()), 64'd1);
    if (glog.size() > 0) check(glog[0], 4'h4);
    $display("test hold done");
  endtask : t_hold

  task automatic t_arb(input logic [1:0] p, input logic [3:0] req);
    glog.delete();
    pol = p; bo_ld = req; bo_v = 10'h000;
    @(negedge clk); bo_ld = 4'h0;
    repeat (20) @(negedge clk);
    check(64'(glog.size()), 64'd2);
    if (glog.size() == 2) begin
      check(64'($onehot(glog[0])), 64'd1);
      check(glog[0] | glog[1], req);
      if (p == chan_timing_pkg::POL_FIXED) check(glog[0], 4'h8);
    end
    $display("test arbitration done");
  endtask : t_arb

  task automatic t_sync;
    int t0 = 0, tb = 0, t1 = 0, c = 0;
    tl = 1'b1; stamp = 64'h100; bl = 1'b1; tbv = 64'h102;
    tr_ld = 2'h1; trv = 64'h101;
    @(negedge clk); tl = 1'b0; bl = 1'b0; tr_ld = 2'h2; trv = 64'h103;
    @(negedge clk); tr_ld = 2'h0;
    check(64'((tsf - 64'h100) <= 64'h1), 64'd1);
    // Sample before each wait: the first tick may follow the load at once
    for (int n = 0; n < 5 * TK; n++) begin
      if (otr[0] === 1'b1) begin t0 = n; c++; end
      if (tbtt === 1'b1) begin tb = n; c++; end
      if (otr[1] === 1'b1) begin t1 = n; c++; end
      @(negedge clk);
    end
    check(64'(c), 64'd3);
    check(64'(tb - t0), 64'(TK));
    check(64'(t1 - tb), 64'(TK));
    $display("test sync done");
  endtask : t_sync

  task automatic t_sleep;
    int n;
    logic [63:0] t;
    sr = 1'b1;
    @(negedge clk); sr = 1'b0;
    check({susp, clk_en}, 2'b10);
    dv = 1'b1; dur = 16'h0010;
    @(negedge clk); dv = 1'b0;
    for (n = 1; n < 100 && clk_en !== 1'b1; n++) @(negedge clk);
    check(64'(n >= 35 && n <= 70), 64'd1);
    check(clk_en, 1'b1);
    t = tsf; ta = 1'b1;
    @(negedge clk); ta = 1'b0;
    @(negedge clk);
    check(64'(tsf - t >= 64'd5 && tsf - t <= 64'd6), 64'd1);
    check({susp, nav}, 2'b00);
    $display("test sleep done");
  endtask : t_sleep

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_spacing();
    t_nav();
    t_hold();
    t_arb(chan_timing_pkg::POL_FIXED, 4'ha);
    t_arb(chan_timing_pkg::POL_ROUND, 4'h5);
    t_sync();
    t_sleep();
    end_of_test();
  end

  // Whole run needs under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule : chan_access_timing_tb_top

// ---- bench/medium_model.sv ----
// Purpose: Far side stand-in: medium activity and slow sleep clock
// Assumes: Driven at the falling edge of the core clock
// Notes:   Slow tick runs free, as a low-power oscillator would
module medium_model #(
  parameter int SLOW_DIV = 10
) (
  input  wire logic clk_i,
  output logic      phy_busy_o,
  output logic      slow_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int div_cnt;

  initial begin
    phy_busy_o  = 1'b0;
    slow_tick_o = 1'b0;
    div_cnt     = 0;
  end

  always @(negedge clk_i) begin
    div_cnt     <= (div_cnt == SLOW_DIV - 1) ? 0 : div_cnt + 1;
    slow_tick_o <= (div_cnt == SLOW_DIV - 1);
  end

  // Medium held busy for n cycles, then released idle
  task automatic occupy(input int n);
    phy_busy_o = 1'b1;
    repeat (n) @(negedge clk_i);
    phy_busy_o = 1'b0;
  endtask : occupy
endmodule : medium_model

// ---- rtl/backoff_arb.sv ----
// Purpose: Picks one access category among those whose counter hit zero
// Assumes: Request vector is one bit per category
// Notes:   Round robin pointer advances only on a grant
module backoff_arb #(
  parameter int unsigned N = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [1:0]   policy_i,
  input  wire logic [N-1:0] req_i,
  output logic      [N-1:0] gnt_o
);
  logic [$clog2(N)-1:0] ptr_reg, ptr_next;
  logic [N-1:0]         gnt;

  always_comb begin
    logic [$clog2(N)-1:0] idx;
    logic                 found;
    idx   = '0;
    found = 1'b0;
    gnt   = '0;
    for (int i = 0; i < N; i++) begin
      if (policy_i == chan_timing_pkg::POL_ROUND)
        idx = ($clog2(N))'((int'(ptr_reg) + i) % N);
      else
        idx = ($clog2(N))'(N - 1 - i);
      if (!found && req_i[idx]) begin
        gnt[idx] = 1'b1;
        found    = 1'b1;
      end
    end
    ptr_next = ptr_reg;
    for (int j = 0; j < N; j++)
      if (gnt[j])
        ptr_next = ($clog2(N))'((j + 1) % N);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      ptr_reg <= '0;
    else
      ptr_reg <= ptr_next;
  end

  assign gnt_o = gnt;

  chk_arb_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    |req_i |-> $onehot(gnt_o) && (gnt_o & ~req_i) == '0)
    else $error("arbiter grant not one-hot");
endmodule : backoff_arb

// ---- rtl/chan_access_timing.sv ----
// Purpose: Channel-access timing: spacing timers, backoff, NAV, TSF, sleep
// Assumes: All inputs synchronous to clk_i; sequencer drives settings
// Notes:   Clock gating is modelled by mac_clk_en_o for the clock gate
module chan_access_timing #(
  parameter int unsigned NUM_AC = chan_timing_pkg::NUM_AC,
  parameter int unsigned NTRIG  = chan_timing_pkg::NUM_TRIG
) (
  input  wire logic                                   clk_i,
  input  wire logic                                   rst_i,
  input  wire logic                                   phy_busy_i,
  input  wire logic [chan_timing_pkg::IFS_W-1:0]      sifs_cyc_i,
  input  wire logic [chan_timing_pkg::IFS_W-1:0]      rifs_cyc_i,
  input  wire logic [chan_timing_pkg::IFS_W-1:0]      slot_cyc_i,
  input  wire logic [NUM_AC-1:0]                      bo_load_i,
  input  wire logic [chan_timing_pkg::BO_W-1:0]       bo_value_i,
  input  wire logic [1:0]                             arb_policy_i,
  input  wire logic                                   dur_valid_i,
  input  wire logic [chan_timing_pkg::NAV_W-1:0]      dur_value_i,
  input  wire logic                                   tsf_load_i,
  input  wire logic [chan_timing_pkg::TSF_W-1:0]      tsf_stamp_i,
  input  wire logic                                   tsf_adv_i,
  input  wire logic                                   tbtt_load_i,
  input  wire logic [chan_timing_pkg::TSF_W-1:0]      tbtt_value_i,
  input  wire logic [NTRIG-1:0]                       trig_load_i,
  input  wire logic [chan_timing_pkg::TSF_W-1:0]      trig_value_i,
  input  wire logic                                   sleep_req_i,
  input  wire logic [chan_timing_pkg::SLEEP_W-1:0]    sleep_count_i,
  input  wire logic                                   slow_tick_i,
  output logic                                        sifs_trig_o,
  output logic                                        rifs_trig_o,
  output logic [NUM_AC-1:0]                           ac_grant_o,
  output logic                                        nav_busy_o,
  output logic                                        tbtt_o,
  output logic [NTRIG-1:0]                            offset_trig_o,
  output logic [chan_timing_pkg::TSF_W-1:0]           tsf_o,
  output logic                                        mac_clk_en_o,
  output logic                                        suspended_o
);
  localparam int unsigned BW = chan_timing_pkg::BO_W;
  localparam int unsigned TW = chan_timing_pkg::TSF_W;

  sleep_if sl ();
  sleep_timer u_sleep (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .slow_tick_i (slow_tick_i),
    .sl          (sl)
  );

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  chan_timing_pkg::pwr_state_t pwr_reg, pwr_next;
  logic                        load_sl, adv_pend_reg, adv_pend_next;
  logic [chan_timing_pkg::SLEEP_W-1:0] slept_reg, slept_next;
  logic                        run;

  always_comb begin
    pwr_next      = pwr_reg;
    load_sl       = 1'b0;
    adv_pend_next = adv_pend_reg;
    slept_next    = slept_reg;
    case (pwr_reg)
      chan_timing_pkg::PWR_RUN: begin
        if (sleep_req_i) begin
          load_sl  = 1'b1;
          pwr_next = chan_timing_pkg::PWR_SUSPEND;
        end
      end
      chan_timing_pkg::PWR_SUSPEND: begin
        if (sl.expired) begin
          slept_next    = sl.elapsed;
          adv_pend_next = 1'b1;
          pwr_next      = chan_timing_pkg::PWR_WAKE;
        end
      end
      chan_timing_pkg::PWR_WAKE: pwr_next = chan_timing_pkg::PWR_RUN;
      default: pwr_next = chan_timing_pkg::PWR_RUN;
    endcase
    if (tsf_adv_i && run)
      adv_pend_next = 1'b0;
  end
  assign sl.load  = load_sl;
  assign sl.count = sleep_count_i;
  assign run      = (pwr_reg != chan_timing_pkg::PWR_SUSPEND);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_reg      <= chan_timing_pkg::PWR_RUN;
      adv_pend_reg <= 1'b0;
      slept_reg    <= '0;
    end else begin
      pwr_reg      <= pwr_next;
      adv_pend_reg <= adv_pend_next;
      slept_reg    <= slept_next;
    end
  end

  // ----------------------------------------------------------------
  // Allocation vector
  // ----------------------------------------------------------------
  logic [chan_timing_pkg::NAV_W-1:0] nav_reg, nav_next;
  logic [$clog2(chan_timing_pkg::TICK_CYC)-1:0] us_reg, us_next;
  logic us_tick;
  assign us_tick = run &&
    (us_reg == ($clog2(chan_timing_pkg::TICK_CYC))'(
      chan_timing_pkg::TICK_CYC - 1));

  always_comb begin
    us_next  = run ? (us_tick ? '0 : us_reg + 1'b1) : us_reg;
    nav_next = nav_reg;
    if (us_tick && nav_reg != '0)
      nav_next = nav_reg - 1'b1;
    if (run && dur_valid_i && dur_value_i > nav_next)
      nav_next = dur_value_i;
  end

  // ----------------------------------------------------------------
  // Spacing timers
  // ----------------------------------------------------------------
  logic                                 busy;
  logic                                 busy_d_reg;
  logic [chan_timing_pkg::IFS_W-1:0]    idle_reg, idle_next;
  logic                                 sifs_next, rifs_next;
  assign busy = phy_busy_i || (nav_reg != '0);

  always_comb begin
    idle_next = '0;
    if (run && !busy)
      idle_next = (&idle_reg) ? idle_reg : idle_reg + 1'b1;
    sifs_next = run && !busy && (idle_next == sifs_cyc_i);
    rifs_next = run && !busy && (idle_next == rifs_cyc_i);
  end

  // ----------------------------------------------------------------
  // Backoff engines
  // ----------------------------------------------------------------
  logic [BW-1:0]                      bo_reg   [NUM_AC];
  logic [BW-1:0]                      bo_next  [NUM_AC];
  logic [NUM_AC-1:0]                  arm_reg, arm_next, req, gnt;
  logic [chan_timing_pkg::IFS_W-1:0]  slot_reg, slot_next;
  logic                               slot_busy_reg, slot_busy_next;
  logic                               slot_end;

  assign slot_end = run && (slot_reg == slot_cyc_i);
  always_comb begin
    slot_next      = slot_end || !run ? '0 : slot_reg + 1'b1;
    slot_busy_next = slot_end ? busy : (slot_busy_reg || busy);
    for (int a = 0; a < NUM_AC; a++) begin
      bo_next[a]  = bo_reg[a];
      arm_next[a] = arm_reg[a];
      req[a]      = arm_reg[a] && bo_reg[a] == '0 && run;
      if (bo_load_i[a]) begin
        bo_next[a]  = bo_value_i;
        arm_next[a] = 1'b1;
      end else if (slot_end && !slot_busy_reg && !busy &&
                   arm_reg[a] && bo_reg[a] != '0) begin
        bo_next[a] = bo_reg[a] - 1'b1;
      end else if (gnt[a]) begin
        arm_next[a] = 1'b0;
      end
    end
  end

  backoff_arb #(.N(NUM_AC)) u_arb (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .policy_i (arb_policy_i),
    .req_i    (req),
    .gnt_o    (gnt)
  );

  // ----------------------------------------------------------------
  // Synchronization timer
  // ----------------------------------------------------------------
  logic [TW-1:0]    tsf_reg, tsf_next, tbtt_reg, tbtt_next;
  logic [TW-1:0]    off_reg [NTRIG];
  logic [TW-1:0]    off_next [NTRIG];
  logic [NTRIG-1:0] otrig_next;
  logic             tbtt_next_p;

  always_comb begin
    tsf_next = tsf_reg;
    if (us_tick)
      tsf_next = tsf_reg + 1'b1;
    if (run && tsf_adv_i && adv_pend_reg)
      tsf_next = tsf_next + TW'(slept_reg);
    if (run && tsf_load_i)
      tsf_next = tsf_stamp_i;
    tbtt_next   = tbtt_load_i ? tbtt_value_i : tbtt_reg;
    tbtt_next_p = run && us_tick && (tsf_reg + 1'b1 == tbtt_reg);
    for (int t = 0; t < NTRIG; t++) begin
      off_next[t]   = trig_load_i[t] ? trig_value_i : off_reg[t];
      otrig_next[t] = run && us_tick && (tsf_reg + 1'b1 == off_reg[t]);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nav_reg       <= chan_timing_pkg::NAV_RST;
      us_reg        <= '0;
      idle_reg      <= '0;
      busy_d_reg    <= 1'b1;
      slot_reg      <= '0;
      slot_busy_reg <= 1'b1;
      arm_reg       <= '0;
      tsf_reg       <= chan_timing_pkg::TSF_RST;
      tbtt_reg      <= chan_timing_pkg::TSF_RST;
      sifs_trig_o   <= 1'b0;
      rifs_trig_o   <= 1'b0;
      ac_grant_o    <= '0;
      nav_busy_o    <= 1'b0;
      tbtt_o        <= 1'b0;
      offset_trig_o <= '0;
      tsf_o         <= chan_timing_pkg::TSF_RST;
      mac_clk_en_o  <= 1'b1;
      suspended_o   <= 1'b0;
      for (int a = 0; a < NUM_AC; a++)
        bo_reg[a] <= '0;
      for (int t = 0; t < NTRIG; t++)
        off_reg[t] <= '0;
    end else begin
      nav_reg       <= nav_next;
      us_reg        <= us_next;
      idle_reg      <= idle_next;
      busy_d_reg    <= busy;
      slot_reg      <= slot_next;
      slot_busy_reg <= slot_busy_next;
      arm_reg       <= arm_next;
      tsf_reg       <= tsf_next;
      tbtt_reg      <= tbtt_next;
      sifs_trig_o   <= sifs_next;
      rifs_trig_o   <= rifs_next;
      ac_grant_o    <= gnt;
      nav_busy_o    <= (nav_next != '0);
      tbtt_o        <= tbtt_next_p;
      offset_trig_o <= otrig_next;
      tsf_o         <= tsf_next;
      mac_clk_en_o  <= (pwr_next != chan_timing_pkg::PWR_SUSPEND);
      suspended_o   <= (pwr_next == chan_timing_pkg::PWR_SUSPEND);
      for (int a = 0; a < NUM_AC; a++)
        bo_reg[a] <= bo_next[a];
      for (int t = 0; t < NTRIG; t++)
        off_reg[t] <= off_next[t];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ifs_idle_start: assert property (@(posedge clk_i) disable iff (rst_i)
    busy |=> idle_reg == '0) else $error("idle count not restarted");
  chk_sifs_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
    sifs_trig_o |-> idle_reg == sifs_cyc_i && !busy_d_reg)
    else $error("spacing trigger at wrong instant");
  chk_grant_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    |req |=> |ac_grant_o) else $error("zero backoff not granted");
  chk_grant_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(ac_grant_o)) else $error("several grants at once");
  chk_suspend_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr_reg == chan_timing_pkg::PWR_RUN && sleep_req_i |=> !mac_clk_en_o)
    else $error("clock not gated on suspend");
  chk_wake_restore: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr_reg == chan_timing_pkg::PWR_SUSPEND && sl.expired |=> mac_clk_en_o)
    else $error("clock not restored on wake");
  chk_tsf_load: assert property (@(posedge clk_i) disable iff (rst_i)
    run && tsf_load_i |=> tsf_o == $past(tsf_stamp_i))
    else $error("timestamp not adopted");
  chk_nav_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    nav_reg != '0 |-> !sifs_next) else $error("trigger while nav busy");
  chk_nav_larger: assert property (@(posedge clk_i) disable iff (rst_i)
    run && dur_valid_i && dur_value_i > nav_reg |=> nav_reg >= $past(dur_value_i) - 1)
    else $error("larger duration not loaded");
  chk_bo_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !slot_end && bo_load_i == '0 |=> bo_reg[0] == $past(bo_reg[0]))
    else $error("backoff moved inside slot");
  cov_sifs: cover property (@(posedge clk_i) sifs_trig_o);
  cov_multi: cover property (@(posedge clk_i) $countones(req) > 1);
  cov_wake: cover property (@(posedge clk_i)
    pwr_reg == chan_timing_pkg::PWR_WAKE);
endmodule : chan_access_timing

// ---- rtl/chan_timing_pkg.sv ----
// Purpose: Shared constants for the channel-access timing block
// Assumes: 50 MHz core clock
// Notes:   All timing counts derive from times in their own unit
package chan_timing_pkg;
  localparam int unsigned CLK_MHZ       = 50;
  // One microsecond tick for allocation-vector countdown
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned NUM_AC        = 4;
  localparam int unsigned BO_W          = 10;
  localparam int unsigned IFS_W         = 12;
  localparam int unsigned NAV_W         = 16;
  localparam int unsigned TSF_W         = 64;
  localparam int unsigned SLEEP_W       = 32;
  localparam int unsigned NUM_TRIG      = 2;
  localparam logic [1:0]  POL_FIXED     = 2'h0;
  localparam logic [1:0]  POL_ROUND     = 2'h1;
  localparam logic [NAV_W-1:0] NAV_RST  = 16'h0000;
  localparam logic [TSF_W-1:0] TSF_RST  = 64'h0;

  typedef enum logic [1:0] {
    PWR_RUN     = 2'b00,
    PWR_SUSPEND = 2'b01,
    PWR_WAKE    = 2'b10
  } pwr_state_t;
endpackage : chan_timing_pkg

// ---- rtl/sleep_if.sv ----
// Purpose: Carries suspend handshake between core and sleep timer
// Assumes: Single clock domain in this model
// Notes:   The sleep timer keeps running while the gate is closed
interface sleep_if;
  logic                                  load;
  logic [chan_timing_pkg::SLEEP_W-1:0]   count;
  logic                                  running;
  logic                                  expired;
  logic [chan_timing_pkg::SLEEP_W-1:0]   elapsed;
  modport core  (output load, output count,
                 input running, input expired, input elapsed);
  modport timer (input load, input count,
                 output running, output expired, output elapsed);
endinterface : sleep_if

// ---- rtl/sleep_timer.sv ----
// Purpose: Slow-clock sleep timer that bounds the suspend period
// Assumes: slow_tick_i is a one-cycle pulse per slow clock period
// Notes:   Runs outside the gated clock domain
module sleep_timer (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic slow_tick_i,
  sleep_if.timer    sl
);
  logic [chan_timing_pkg::SLEEP_W-1:0] cnt_reg, cnt_next;
  logic [chan_timing_pkg::SLEEP_W-1:0] el_reg, el_next;
  logic                                run_reg, run_next;
  logic                                exp_reg, exp_next;

  always_comb begin
    cnt_next = cnt_reg;
    el_next  = el_reg;
    run_next = run_reg;
    exp_next = 1'b0;
    if (sl.load) begin
      cnt_next = sl.count;
      el_next  = '0;
      run_next = (sl.count != '0);
      exp_next = (sl.count == '0);
    end else if (run_reg && slow_tick_i) begin
      cnt_next = cnt_reg - 1'b1;
      el_next  = el_reg + 1'b1;
      if (cnt_reg == {{(chan_timing_pkg::SLEEP_W-1){1'b0}}, 1'b1}) begin
        run_next = 1'b0;
        exp_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      el_reg  <= '0;
      run_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      el_reg  <= el_next;
      run_reg <= run_next;
      exp_reg <= exp_next;
    end
  end

  assign sl.running = run_reg;
  assign sl.expired = exp_reg;
  assign sl.elapsed = el_reg;

  chk_sleep_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
    run_reg && slow_tick_i && !sl.load && cnt_reg == 1 |=> exp_reg && !run_reg)
    else $error("sleep timer missed expiry");
endmodule : sleep_timer
